// File: bench/pmc_partner.sv
// far-side model: halt-release pin, time base source and oscillator ticks
`default_nettype none
module pmc_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_level,
  output logic halt_pin_in,
  output logic tb_src_in,
  output logic fast_tick,
  output logic slow_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end
  // pin has no pull: it shows only what the bench commands
  assign halt_pin_in = pin_level;
  // time base source runs free, falling every 16 cycles
  assign tb_src_in = cnt_q[3];
  assign fast_tick = 1'b1;
  // slow clock four times slower keeps slow warm-up short
  assign slow_tick = (cnt_q[1:0] == 2'h3);
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the power mode controller
`default_nettype none
`include "pmc_defines.svh"
module tb_top import pmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, irq_req_in = 1'b0, pin_level = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd, hrdata;
  logic hreadyout, hresp, halt_pin_in, tb_src_in, fast_tick, slow_tick, halt_pin_oe_n;
  logic fast_osc_on, slow_osc_on, cpu_clk_slow, cpu_run, wdt_run, periph_clk_en;
  logic div_low_run, time_base_int_latch, time_base_irq;
  logic [7:0] port_out, port_oe_n, port_in_eff;
  logic [3:0] mode;
  int errors = 0, compares = 0;
  always #50 hclk = ~hclk;
  pmc_partner pmc_partner_i (.hclk(hclk), .hresetn(hresetn), .pin_level(pin_level),
    .halt_pin_in(halt_pin_in), .tb_src_in(tb_src_in), .fast_tick(fast_tick),
    .slow_tick(slow_tick));
  pmc_top pmc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_pin_in(halt_pin_in),
    .irq_req_in(irq_req_in), .tb_src_in(tb_src_in), .fast_tick(fast_tick),
    .slow_tick(slow_tick), .port_out_val(8'hA5), .port_in_raw(8'hFF), .port_out(port_out),
    .port_oe_n(port_oe_n), .port_in_eff(port_in_eff), .halt_pin_oe_n(halt_pin_oe_n),
    .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on), .cpu_clk_slow(cpu_clk_slow),
    .cpu_run(cpu_run), .wdt_run(wdt_run), .periph_clk_en(periph_clk_en),
    .div_low_run(div_low_run), .time_base_int_latch(time_base_int_latch),
    .time_base_irq(time_base_irq), .mode(mode));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_for(input pmc_mode_t m, input int lim, output int n);
    n = 0;
    while (mode !== m && n < lim)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk("mode", 32'(mode), 32'(m));
  endtask
  task automatic t_reset();
    chk("mode_rst", 32'(mode), 32'(PMC_FAST1));
    chk("clk_slow_rst", 32'(cpu_clk_slow), 32'h0);
    xfer(`PMC_OFS_CTRL1, 1'b0, 32'h0);
    chk("ctrl1", rd, {24'h0, `PMC_CTRL1_RESET});
    xfer(`PMC_OFS_CTRL2, 1'b0, 32'h0);
    chk("ctrl2", rd, {24'h0, `PMC_CTRL2_RESET});
    xfer(`PMC_OFS_CTRL1, 1'b1, 32'h0F);
    xfer(`PMC_OFS_CTRL1, 1'b0, 32'h0);
    chk("ctrl1_low", rd, 32'h0C);
    xfer(12'h100, 1'b1, 32'hFFFFFFFF);
    xfer(12'h100, 1'b0, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
    $display("test reset done");
  endtask
  task automatic halt_wake(input logic [7:0] run, input pmc_mode_t rm, input pmc_mode_t hm);
    int n;
    xfer(`PMC_OFS_CTRL2, 1'b1, {24'h0, run});
    wait_for(rm, 40, n);
    chk("div_run", 32'(div_low_run), 32'(!run[5]));
    chk("clk_slow", 32'(cpu_clk_slow), 32'(run[5]));
    chk("fosc_run", 32'(fast_osc_on), 32'(run[7]));
    xfer(`PMC_OFS_CTRL2, 1'b1, {24'h0, run | 8'h10});
    wait_for(hm, 40, n);
    chk("cpu_wdt", 32'({cpu_run, wdt_run, slow_osc_on}), 32'h1);
    chk("fosc_halt", 32'(fast_osc_on), 32'(run[7]));
    chk("div_halt", 32'(div_low_run), 32'(!run[5]));
    irq_req_in <= 1'b1;
    wait_for(rm, 40, n);
    irq_req_in <= 1'b0;
    $display("test halt_wake %h done", run);
  endtask
  task automatic t_tbase();
    int n;
    xfer(`PMC_OFS_TBASE, 1'b1, 32'h7);
    xfer(`PMC_OFS_CTRL2, 1'b1, 32'h64);
    wait_for(PMC_TB_HALT, 40, n);
    chk("periph_en", 32'({periph_clk_en, cpu_run}), 32'h0);
    wait_for(PMC_LOWCLK_RUN_FASTOSC_OFF, 40, n);
    xfer(`PMC_OFS_CTRL2, 1'b0, 32'h0);
    chk("gate_clr", rd & 32'h4, 32'h0);
    chk("tb_latch", 32'({time_base_int_latch, time_base_irq}), 32'h3);
    $display("test tbase done");
  endtask
  task automatic t_osc_slow();
    int n;
    xfer(`PMC_OFS_CTRL1, 1'b1, 32'hAC);
    wait_for(PMC_OSC_HALT, 40, n);
    chk("osc_off", 32'({fast_osc_on, slow_osc_on, cpu_run}), 32'h0);
    chk("pin_oe_n", 32'(halt_pin_oe_n), 32'h1);
    chk("port_oe_n", 32'(port_oe_n), 32'hFF);
    chk("port_in", 32'(port_in_eff), 32'h0);
    repeat (4) @(posedge hclk);
    chk("held", 32'(mode), 32'(PMC_OSC_HALT));
    pin_level <= 1'b1;
    wait_for(PMC_LOWCLK_RUN_FASTOSC_OFF, 2000, n);
    chk("wut_slow", 32'(n >= 256 && n <= 280), 32'h1);
    $display("test osc_slow done");
  endtask
  task automatic t_osc_fast();
    int n;
    xfer(`PMC_OFS_CTRL2, 1'b1, 32'hE0);
    wait_for(PMC_LOWCLK_RUN_FASTOSC_ON, 40, n);
    xfer(`PMC_OFS_CTRL2, 1'b1, 32'hC0);
    wait_for(PMC_FAST2, 40, n);
    // level release: the pin must be low or the halt releases at once
    pin_level <= 1'b0;
    repeat (4) @(posedge hclk);
    xfer(`PMC_OFS_CTRL1, 1'b1, 32'hDC);
    wait_for(PMC_OSC_HALT, 40, n);
    chk("hold_oe_n", 32'(port_oe_n), 32'h0);
    chk("hold_out", 32'(port_out), 32'hA5);
    chk("hold_in", 32'(port_in_eff), 32'hFF);
    chk("pin_oe_n2", 32'(halt_pin_oe_n), 32'h1);
    pin_level <= 1'b1;
    n = 0;
    while ((mode === PMC_OSC_HALT || mode === PMC_WARMUP) && n < 17000)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk("ret_fast", 32'(mode === PMC_FAST1 || mode === PMC_FAST2), 32'h1);
    chk("wut_fast", 32'(n >= 16384 && n <= 16400), 32'h1);
    $display("test osc_fast done");
  endtask
  task automatic t_osc_reset();
    int n;
    // return mode set to slow on purpose: a reset must override it
    xfer(`PMC_OFS_CTRL1, 1'b1, 32'hAC);
    wait_for(PMC_OSC_HALT, 40, n);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk("rst_ret", 32'(mode), 32'(PMC_FAST1));
    $display("test osc_reset done");
  endtask
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    t_reset();
    halt_wake(8'hC0, PMC_FAST2, PMC_FAST2_HALT);
    halt_wake(8'hE0, PMC_LOWCLK_RUN_FASTOSC_ON, PMC_LOWCLK_RUN_FASTOSC_ON_HALT);
    halt_wake(8'h60, PMC_LOWCLK_RUN_FASTOSC_OFF, PMC_LOWCLK_RUN_FASTOSC_OFF_HALT);
    t_tbase();
    t_osc_slow();
    t_osc_fast();
    t_osc_reset();
    close_out();
  end
  initial
  begin
    #6000000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire

// File: include/pmc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_OFS_CTRL1 12'h038
`define PMC_OFS_CTRL2 12'h039
`define PMC_OFS_STATUS 12'h03C
`define PMC_OFS_TBASE 12'h040
`define PMC_CTRL1_RESET 8'h00
`define PMC_CTRL2_RESET 8'h80
`define PMC_B_HALT_REQ 7
`define PMC_B_RELSENS 6
`define PMC_B_RETMODE 5
`define PMC_B_PORTHOLD 4
`define PMC_B_WUT_HI 3
`define PMC_B_WUT_LO 2
`define PMC_B_FOSC_EN 7
`define PMC_B_SOSC_EN 6
`define PMC_B_MAINSEL 5
`define PMC_B_CPUHALT 4
`define PMC_B_TGATE 2
`define PMC_B_TB_EN 0
`define PMC_B_TB_IE 1
`define PMC_B_MIE 2
`define PMC_WUT_F0 32'd196608
`define PMC_WUT_F1 32'd65536
`define PMC_WUT_F2 32'd49152
`define PMC_WUT_F3 32'd16384
`define PMC_WUT_S0 32'd24576
`define PMC_WUT_S1 32'd8192
`define PMC_WUT_S2 32'd192
`define PMC_WUT_S3 32'd64
`endif

// File: include/pmc_pkg.sv
// types of the power mode controller
`default_nettype none
package pmc_pkg;
  typedef enum logic [3:0] {
    PMC_FAST1 = 4'h0,
    PMC_FAST1_HALT = 4'h1,
    PMC_FAST2 = 4'h3,
    PMC_FAST2_HALT = 4'h2,
    PMC_LOWCLK_RUN_FASTOSC_ON = 4'h6,
    PMC_LOWCLK_RUN_FASTOSC_ON_HALT = 4'h7,
    PMC_LOWCLK_RUN_FASTOSC_OFF = 4'h5,
    PMC_LOWCLK_RUN_FASTOSC_OFF_HALT = 4'h4,
    PMC_TB_HALT = 4'hC,
    PMC_OSC_HALT = 4'hD,
    PMC_WARMUP = 4'hF
  } pmc_mode_t;
endpackage
`default_nettype wire

// File: logic/pmc_top.sv
// power mode controller with ahb-lite registers
// How it works
// RULE1 - lowclk_run_fastosc_off: fast oscillator off, cpu and peripherals on slow clock
// RULE2 - fast_osc_enable chooses lowclk_run_fastosc_off or lowclk_run_fastosc_on while in slow run
// RULE3 - in slow run or slow halt the divider stages one to six freeze
// RULE4 - dual fast halt keeps oscillators, stops cpu and watchdog, returns to dual run
// RULE5 - lowclk_run_fastosc_off halt stops cpu, watchdog, fast oscillator; returns to lowclk_run_fastosc_off
// RULE6 - lowclk_run_fastosc_on halt equals lowclk_run_fastosc_off halt but fast oscillator keeps running
// RULE7 - periph_clock_gate set in slow mode enters timebase-only halt
// RULE8 - timebase-only halt gates peripherals until time base source falls
// RULE9 - timebase-only halt returns to lowclk_run_fastosc_off, regardless of time_base_enable
// RULE10 - time base enabled at entry sets the latch; service needs three enables
// RULE11 - oscillator-off halt stops all oscillators and holds state
// RULE12 - halt request bit starts it; pin releases by edge or level
// RULE13 - after release the warm-up runs, then execution resumes
// RULE14 - return_mode_select picks fast run (0) or lowclk_run_fastosc_off (1)
// RULE15 - software sets return_mode_select to match the mode it halts from
// RULE16 - a reset ending the halt always returns to single fast run
// RULE17 - ports float unless port_hold_in_halt keeps their levels
// RULE18 - without port hold, port inputs are forced to zero
// RULE19 - warmup_select picks one of four warm-up lengths per return clock
// RULE20 - low two bits of sys_ctrl_reg_one read undefined (here zero)
// RULE21 - key-on wakeup release needs level-sensitive release selected
// RULE22 - halt_pin_port floats in oscillator-off halt whatever port hold says
// RULE23 - after reset the device runs in single fast run
// RULE24 - an interrupt request ends a cpu halt, back to its run mode
// RULE25 - main_clock_select moves cpu between fast and slow clock
// RULE26 - periph_clock_gate clears itself when timebase-only halt ends
// RULE27 - warm-up counts the return clock up to the selected length
//
// The AHB-Lite interface to the registers was left to the implementer.
`default_nettype none
`include "pmc_defines.svh"
module pmc_top
  import pmc_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int WCW = 18
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic halt_pin_in,
  input wire logic irq_req_in,
  input wire logic tb_src_in,
  input wire logic fast_tick,
  input wire logic slow_tick,
  input wire logic [PORT_W-1:0] port_out_val,
  input wire logic [PORT_W-1:0] port_in_raw,
  output logic [PORT_W-1:0] port_out,
  output logic [PORT_W-1:0] port_oe_n,
  output logic [PORT_W-1:0] port_in_eff,
  output logic halt_pin_oe_n,
  output logic fast_osc_on,
  output logic slow_osc_on,
  output logic cpu_clk_slow,
  output logic cpu_run,
  output logic wdt_run,
  output logic periph_clk_en,
  output logic div_low_run,
  output logic time_base_int_latch,
  output logic time_base_irq,
  output logic [3:0] mode
);
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [2:0] tbctl;
    logic wr_pend;
    logic [11:0] addr;
    pmc_mode_t md;
    logic ret_slow;
    logic tb_arm;
    logic tb_latch;
    logic rel_armed;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic tb_s1;
    logic tb_s2;
    logic tb_s3;
    logic irq_s1;
    logic irq_s2;
    logic [PORT_W-1:0] held;
  } pmc_st_t;
  pmc_st_t s_q, s_d;
  logic wu_start, wu_done;
  logic [31:0] rd;
  logic slow_md, osc_halt;
  pmc_warmup #(.CW(WCW)) u_wu (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(wu_start),
    .to_slow(s_q.ret_slow),
    .sel(s_q.ctrl1[`PMC_B_WUT_HI:`PMC_B_WUT_LO]),
    .fast_tick(fast_tick),
    .slow_tick(slow_tick),
    .done(wu_done)
  );
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mode = s_q.md;
  assign osc_halt = (s_q.md == PMC_OSC_HALT);
  assign slow_md = (s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF) || (s_q.md == PMC_LOWCLK_RUN_FASTOSC_ON) ||
                   (s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF_HALT) || (s_q.md == PMC_LOWCLK_RUN_FASTOSC_ON_HALT) ||
                   (s_q.md == PMC_TB_HALT);
  always_comb
  begin
    rd = 32'h0000_0000;
    // decoded in the address phase from next state, so a write just landing is seen
    unique case (haddr)
      `PMC_OFS_CTRL1: rd = {24'h000000, s_d.ctrl1[7:2], 2'b00}; // [RULE20]
      `PMC_OFS_CTRL2: rd = {24'h000000, s_d.ctrl2[7:4], 1'b0, s_d.ctrl2[2], 2'b00};
      `PMC_OFS_STATUS: rd = {27'h0000000, s_d.tb_latch, s_d.md};
      `PMC_OFS_TBASE: rd = {29'h00000000, s_d.tbctl};
      default: rd = 32'h0000_0000;
    endcase
  end
  always_comb
  begin
    s_d = s_q;
    wu_start = 1'b0;
    s_d.pin_s1 = halt_pin_in;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    s_d.tb_s1 = tb_src_in;
    s_d.tb_s2 = s_q.tb_s1;
    s_d.tb_s3 = s_q.tb_s2;
    s_d.irq_s1 = irq_req_in;
    s_d.irq_s2 = s_q.irq_s1;
    s_d.wr_pend = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      s_d.addr = haddr;
      s_d.wr_pend = hwrite;
    end
    else if (hready)
      s_d.addr = 12'hFFF;
    if (s_q.wr_pend)
    begin
      unique case (s_q.addr)
        `PMC_OFS_CTRL1: s_d.ctrl1 = {hwdata[7:2], 2'b00};
        `PMC_OFS_CTRL2: s_d.ctrl2 = {hwdata[7:4], 1'b0, hwdata[2], 2'b00};
        `PMC_OFS_TBASE: s_d.tbctl = hwdata[2:0];
        default: s_d.ctrl1 = s_q.ctrl1;
      endcase
    end
    unique case (s_q.md)
      PMC_FAST1, PMC_FAST2, PMC_LOWCLK_RUN_FASTOSC_OFF, PMC_LOWCLK_RUN_FASTOSC_ON:
      begin
        if (s_d.ctrl1[`PMC_B_HALT_REQ]) // [RULE11] [RULE12]
        begin
          s_d.md = PMC_OSC_HALT;
          s_d.rel_armed = 1'b0;
          s_d.ret_slow = s_d.ctrl1[`PMC_B_RETMODE];
          s_d.held = port_out_val;
        end
        else if (s_d.ctrl2[`PMC_B_TGATE] && (s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF || s_q.md == PMC_LOWCLK_RUN_FASTOSC_ON))
        begin
          s_d.md = PMC_TB_HALT; // [RULE7] [RULE8]
          s_d.tb_arm = s_q.tbctl[`PMC_B_TB_EN];
        end
        else if (s_d.ctrl2[`PMC_B_CPUHALT])
          unique case (s_q.md)
            PMC_FAST1: s_d.md = PMC_FAST1_HALT;
            PMC_FAST2: s_d.md = PMC_FAST2_HALT; // [RULE4]
            PMC_LOWCLK_RUN_FASTOSC_OFF: s_d.md = PMC_LOWCLK_RUN_FASTOSC_OFF_HALT; // [RULE5]
            default: s_d.md = PMC_LOWCLK_RUN_FASTOSC_ON_HALT; // [RULE6]
          endcase
        else if (s_d.ctrl2[`PMC_B_MAINSEL])
          s_d.md = s_d.ctrl2[`PMC_B_FOSC_EN] ? PMC_LOWCLK_RUN_FASTOSC_ON : PMC_LOWCLK_RUN_FASTOSC_OFF; // [RULE1] [RULE2] [RULE25]
        else
          s_d.md = s_d.ctrl2[`PMC_B_SOSC_EN] ? PMC_FAST2 : PMC_FAST1; // [RULE25]
      end
      PMC_FAST1_HALT, PMC_FAST2_HALT, PMC_LOWCLK_RUN_FASTOSC_OFF_HALT, PMC_LOWCLK_RUN_FASTOSC_ON_HALT:
        if (s_q.irq_s2) // [RULE24]
        begin
          s_d.ctrl2[`PMC_B_CPUHALT] = 1'b0;
          unique case (s_q.md)
            PMC_FAST1_HALT: s_d.md = PMC_FAST1;
            PMC_FAST2_HALT: s_d.md = PMC_FAST2; // [RULE4]
            PMC_LOWCLK_RUN_FASTOSC_OFF_HALT: s_d.md = PMC_LOWCLK_RUN_FASTOSC_OFF; // [RULE5]
            default: s_d.md = PMC_LOWCLK_RUN_FASTOSC_ON; // [RULE6]
          endcase
        end
      PMC_TB_HALT:
        if (s_q.tb_s3 && !s_q.tb_s2) // [RULE8]
        begin
          s_d.md = PMC_LOWCLK_RUN_FASTOSC_OFF; // [RULE9]
          s_d.ctrl2[`PMC_B_TGATE] = 1'b0; // [RULE26]
          s_d.ctrl2[`PMC_B_MAINSEL] = 1'b1;
          s_d.ctrl2[`PMC_B_FOSC_EN] = 1'b0;
          if (s_q.tb_arm)
            s_d.tb_latch = 1'b1; // [RULE10]
        end
      PMC_OSC_HALT:
      begin
        if (!s_q.pin_s2)
          s_d.rel_armed = 1'b1;
        // level mode releases on a high pin, edge mode needs a low first
        if (s_q.pin_s2 && (s_q.rel_armed || s_q.ctrl1[`PMC_B_RELSENS])) // [RULE12]
        begin
          s_d.md = PMC_WARMUP;
          wu_start = 1'b1; // [RULE13]
        end
      end
      PMC_WARMUP:
        if (wu_done) // [RULE13]
        begin
          s_d.ctrl1[`PMC_B_HALT_REQ] = 1'b0;
          s_d.md = s_q.ret_slow ? PMC_LOWCLK_RUN_FASTOSC_OFF : PMC_FAST1; // [RULE14]
          s_d.ctrl2[`PMC_B_MAINSEL] = s_q.ret_slow;
          if (s_q.ret_slow)
            s_d.ctrl2[`PMC_B_FOSC_EN] = 1'b0;
        end
      default: s_d.md = PMC_FAST1;
    endcase
    // software clear through the status register loses to a new set
    if (s_q.wr_pend && s_q.addr == `PMC_OFS_STATUS && hwdata[4] &&
        !(s_q.md == PMC_TB_HALT && s_d.md == PMC_LOWCLK_RUN_FASTOSC_OFF && s_q.tb_arm))
      s_d.tb_latch = 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0; // [RULE16] [RULE23]
      s_q.ctrl1 <= `PMC_CTRL1_RESET;
      s_q.ctrl2 <= `PMC_CTRL2_RESET;
      s_q.md <= PMC_FAST1;
      s_q.addr <= 12'hFFF;
    end
    else
      s_q <= s_d;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hsel && hready && htrans[1] && !hwrite)
      hrdata <= rd;
    else
      hrdata <= 32'h0000_0000;
  end
  always_comb
  begin
    fast_osc_on = !osc_halt && (s_q.md != PMC_WARMUP || !s_q.ret_slow) &&
                  !(s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF || s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF_HALT ||
                    s_q.md == PMC_TB_HALT); // [RULE1] [RULE5] [RULE11]
    slow_osc_on = !osc_halt && (s_q.md != PMC_FAST1) && (s_q.md != PMC_FAST1_HALT);
    cpu_clk_slow = slow_md || (s_q.md == PMC_WARMUP && s_q.ret_slow); // [RULE1]
    cpu_run = (s_q.md == PMC_FAST1) || (s_q.md == PMC_FAST2) ||
              (s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF) || (s_q.md == PMC_LOWCLK_RUN_FASTOSC_ON);
    wdt_run = cpu_run;
    periph_clk_en = (s_q.md != PMC_TB_HALT) && !osc_halt && (s_q.md != PMC_WARMUP); // [RULE8]
    div_low_run = !slow_md && !osc_halt; // [RULE3]
    time_base_int_latch = s_q.tb_latch;
    time_base_irq = s_q.tb_latch && s_q.tbctl[`PMC_B_MIE] &&
                    s_q.tbctl[`PMC_B_TB_IE] && s_q.tbctl[`PMC_B_TB_EN]; // [RULE10]
    halt_pin_oe_n = osc_halt; // [RULE22]
    for (int i = 0; i < PORT_W; i++)
    begin
      port_out[i] = osc_halt ? s_q.held[i] : port_out_val[i];
      port_oe_n[i] = osc_halt && !s_q.ctrl1[`PMC_B_PORTHOLD]; // [RULE17]
      port_in_eff[i] = (osc_halt && !s_q.ctrl1[`PMC_B_PORTHOLD]) ? 1'b0 : port_in_raw[i]; // [RULE18]
    end
  end
  a_tb_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.md == PMC_TB_HALT && s_q.tb_s3 && !s_q.tb_s2) |=> (s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF &&
    !s_q.ctrl2[`PMC_B_TGATE])) else $error("timebase halt exit wrong"); // [RULE9] [RULE26]
  a_tb_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.md == PMC_TB_HALT && s_q.tb_arm && s_q.tb_s3 && !s_q.tb_s2) |=> s_q.tb_latch)
    else $error("time base latch not set"); // [RULE10]
  a_wu_return: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.md == PMC_WARMUP && wu_done) |=> (s_q.md == ($past(s_q.ret_slow) ? PMC_LOWCLK_RUN_FASTOSC_OFF :
    PMC_FAST1))) else $error("return mode wrong"); // [RULE14]
  a_port_float: assert property (@(posedge hclk) disable iff (!hresetn)
    osc_halt |-> (halt_pin_oe_n && (port_oe_n == {PORT_W{!s_q.ctrl1[`PMC_B_PORTHOLD]}})))
    else $error("port drive wrong in halt"); // [RULE17] [RULE22]
  a_div_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF) |-> (!div_low_run && !fast_osc_on && cpu_clk_slow))
    else $error("lowclk_run_fastosc_off clocks wrong"); // [RULE1] [RULE3]
  a_halt_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF_HALT && s_q.irq_s2) |=> (s_q.md == PMC_LOWCLK_RUN_FASTOSC_OFF && cpu_run))
    else $error("halt wake wrong"); // [RULE5] [RULE24]
  a_osc_off: assert property (@(posedge hclk) disable iff (!hresetn)
    osc_halt |-> (!fast_osc_on && !slow_osc_on && !cpu_run)) else $error("osc not off"); // [RULE11]
  a_pin_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (osc_halt && !s_q.ctrl1[`PMC_B_PORTHOLD]) |-> (port_in_eff == '0))
    else $error("inputs not forced"); // [RULE18]
endmodule
`default_nettype wire

// File: logic/pmc_warmup.sv
// warm-up counter for halt release
`default_nettype none
`include "pmc_defines.svh"
module pmc_warmup
  import pmc_pkg::*;
#(
  parameter int CW = 18
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic to_slow,
  input wire logic [1:0] sel,
  input wire logic fast_tick,
  input wire logic slow_tick,
  output logic done
);
  typedef struct packed {
    logic run;
    logic [CW-1:0] cnt;
    logic [CW-1:0] lim;
    logic slow;
  } pmc_wu_t;
  pmc_wu_t s_q, s_d;
  logic [31:0] lim_w;
  always_comb
  begin
    unique case ({to_slow, sel})
      3'b000: lim_w = `PMC_WUT_F0;
      3'b001: lim_w = `PMC_WUT_F1;
      3'b010: lim_w = `PMC_WUT_F2;
      3'b011: lim_w = `PMC_WUT_F3;
      3'b100: lim_w = `PMC_WUT_S0;
      3'b101: lim_w = `PMC_WUT_S1;
      3'b110: lim_w = `PMC_WUT_S2;
      default: lim_w = `PMC_WUT_S3;
    endcase
  end
  always_comb
  begin
    s_d = s_q;
    done = s_q.run && (s_q.cnt == s_q.lim);
    if (start)
    begin
      s_d.run = 1'b1;
      s_d.cnt = '0;
      s_d.lim = lim_w[CW-1:0];
      s_d.slow = to_slow;
    end
    else if (done)
      s_d.run = 1'b0;
    else if (s_q.run && (s_q.slow ? slow_tick : fast_tick)) // [RULE27]
      s_d.cnt = s_q.cnt + 1'b1;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule
`default_nettype wire
